// *** autoneg_adv_pkg.sv ***
// Constants for the per-port auto-negotiation advertisement register block.
// Assumes a 32-bit classic Wishbone slave port and a 100 MHz mclk.
`default_nettype none
package autoneg_adv_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int ADV_W = 16;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADV_OFFSET        = 8'h04;
    localparam logic [7:0] LOAD_CTRL_OFFSET  = 8'h40;
    localparam logic [7:0] STRAP_STAT_OFFSET = 8'h44;

    // ==========================================================
    // Advertisement field positions
    localparam int BIT_REMOTE_FAULT = 13;
    localparam int BIT_RSVD_12      = 12;
    localparam int BIT_ASYM_PAUSE   = 11;
    localparam int BIT_SYM_PAUSE    = 10;
    localparam int BIT_100_FULL     = 8;
    localparam int BIT_100_HALF     = 7;
    localparam int BIT_10_FULL      = 6;
    localparam int BIT_10_HALF      = 5;
    localparam int SEL_FIELD_LSB    = 0;
    localparam int SEL_FIELD_W      = 5;

    localparam logic [4:0]  SEL_IEEE_8023  = 5'h01;
    // Writable bits; 15, 14 and 9 always read zero
    localparam logic [15:0] ADV_WR_MASK    = 16'h3dff;
    // Fixed reset image: 100 full/half and selector, strap bits clear
    localparam logic [15:0] ADV_RESET_BASE = 16'h0181;

    // ==========================================================
    // Load control and strap status fields
    localparam int RELOAD_BIT    = 0;
    localparam int STRAP_AUTONEG = 0;
    localparam int STRAP_SPEED   = 1;
    localparam int STRAP_DUPLEX  = 2;
    localparam int STRAP_MAN_FC  = 3;
    localparam int STRAP_W       = 4;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_LOAD  = 3'b010,
        ST_IDLE  = 3'b100
    } load_state_t;

endpackage
`default_nettype wire

// *** strap_defaults.sv ***
// Strap capture and strap-dependent advertisement defaults.
// Assumes straps are stable around the release of the synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module strap_defaults
    import autoneg_adv_pkg::*;
(
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           autoneg_strap,
    input  wire logic                           speed_strap,
    input  wire logic                           duplex_strap,
    input  wire logic                           manual_flow_ctrl_strap,
    output logic [autoneg_adv_pkg::STRAP_W-1:0] strap_word,
    output logic                                capture_pulse,
    output logic [autoneg_adv_pkg::ADV_W-1:0]   default_word
);

    import autoneg_adv_pkg::*;

    logic                 captured;
    logic                 next_captured;
    logic                 next_capture_pulse;
    logic [STRAP_W-1:0]   next_strap_word;

    // ==========================================================
    // Capture once, at the first edge after reset release
    always_comb begin
        next_captured      = 1'b1;
        next_capture_pulse = !captured;
        next_strap_word    = strap_word;
        if (!captured) begin
            next_strap_word = {manual_flow_ctrl_strap, duplex_strap,
                               speed_strap, autoneg_strap};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            captured      <= 1'b0;
            capture_pulse <= 1'b0;
            strap_word    <= '0;
        end else begin
            captured      <= next_captured;
            capture_pulse <= next_capture_pulse;
            strap_word    <= next_strap_word;
        end
    end

    // ==========================================================
    // Default image from latched straps
    always_comb begin
        default_word = ADV_RESET_BASE;
        default_word[BIT_SYM_PAUSE] = !strap_word[STRAP_MAN_FC];
        default_word[BIT_10_FULL]   = strap_word[STRAP_AUTONEG] |
            (!strap_word[STRAP_SPEED] & strap_word[STRAP_DUPLEX]);
        default_word[BIT_10_HALF]   = strap_word[STRAP_AUTONEG] |
            !strap_word[STRAP_SPEED];
    end

endmodule
`default_nettype wire

// *** autoneg_advert_register.sv ***
// Auto-negotiation advertisement register with Wishbone access and
// an EEPROM loader port. Assumes the loader answers load_request with
// a one-cycle loader_valid carrying the full register image.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 16-bit read/write register at index 4 holds advertised abilities.
// - Loader rewrites the register after reset release and after reload.
// - Loader image supplies symmetric and asymmetric pause bits.
// - Bit 13 read/write, reset 0, advertises remote fault when set.
// - Bit 11 read/write, reset 0, advertises asymmetric pause when set.
// - Bit 10 symmetric pause defaults to NOT manual flow control strap.
// - Bit 8 read/write, reset 1, advertises 100 full duplex.
// - Bit 7 read/write, reset 1, advertises 100 half duplex.
// - Bit 6 defaults to autoneg strap OR (not speed AND duplex).
// - Bit 5 defaults to autoneg strap OR not speed strap.
// - Bits 4:0 selector, read/write, reset 00001 for IEEE 802.3.
// - Straps are captured at reset release and held afterwards.
module autoneg_advert_register
    import autoneg_adv_pkg::*;
(
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [autoneg_adv_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [autoneg_adv_pkg::SEL_W-1:0] wb_sel_i,
    input  wire logic [autoneg_adv_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [autoneg_adv_pkg::DAT_W-1:0] wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       autoneg_strap,
    input  wire logic                       speed_strap,
    input  wire logic                       duplex_strap,
    input  wire logic                       manual_flow_ctrl_strap,
    input  wire logic                       loader_valid,
    input  wire logic [autoneg_adv_pkg::ADV_W-1:0] loader_data,
    output logic                            load_request,
    output logic      [autoneg_adv_pkg::ADV_W-1:0] advert
);

    import autoneg_adv_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [ADV_W-1:0] clean_adv(
        input logic [ADV_W-1:0] word
    );
        clean_adv = word & ADV_WR_MASK;
    endfunction

    load_state_t          state;
    load_state_t          next_state;
    logic [ADV_W-1:0]     next_advert;
    logic                 next_load_request;
    logic [ADV_W-1:0]     merged;
    logic [STRAP_W-1:0]   strap_word;
    logic                 capture_pulse;
    logic [ADV_W-1:0]     default_word;
    logic                 bus_req;
    logic                 wr_adv;
    logic                 reload_cmd;
    logic                 next_ack;
    logic [DAT_W-1:0]     next_rdata;

    strap_defaults u_straps (
        .mclk                   (mclk),
        .rst                    (rst),
        .autoneg_strap          (autoneg_strap),
        .speed_strap            (speed_strap),
        .duplex_strap           (duplex_strap),
        .manual_flow_ctrl_strap (manual_flow_ctrl_strap),
        .strap_word             (strap_word),
        .capture_pulse          (capture_pulse),
        .default_word           (default_word)
    );

    // ==========================================================
    // Request decode
    assign bus_req    = wb_cyc_i & wb_stb_i & !wb_ack_o;
    assign wr_adv     = bus_req & wb_we_i & (wb_adr_i == ADV_OFFSET);
    assign reload_cmd = bus_req & wb_we_i & wb_sel_i[0] &
                        (wb_adr_i == LOAD_CTRL_OFFSET) &
                        wb_dat_i[RELOAD_BIT];

    // Byte lanes 0 and 1 carry the register; lanes 2 and 3 are dropped
    always_comb begin
        merged = advert;
        if (wb_sel_i[0]) begin
            merged[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            merged[15:8] = wb_dat_i[15:8];
        end
    end

    // ==========================================================
    // Register contents and loader sequencing
    always_comb begin
        next_state  = state;
        next_advert = advert;
        unique case (state)
            ST_STRAP: begin
                if (capture_pulse) begin
                    next_advert = clean_adv(default_word);
                    next_state  = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (wr_adv) begin
                    next_advert = clean_adv(merged);
                end
                // Loader image wins over a same-cycle bus write
                if (loader_valid) begin
                    next_advert = clean_adv(loader_data);
                    next_state  = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wr_adv) begin
                    next_advert = clean_adv(merged);
                end
            end
        endcase
        // A reload arriving as a load completes is kept, not lost
        if (reload_cmd && state != ST_STRAP) begin
            next_state = ST_LOAD;
        end
        next_load_request = (next_state == ST_LOAD);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state        <= ST_STRAP;
            advert       <= ADV_RESET_BASE;
            load_request <= 1'b0;
        end else begin
            state        <= next_state;
            advert       <= next_advert;
            load_request <= next_load_request;
        end
    end

    // ==========================================================
    // Wishbone answer: one wait state, unmapped reads return zero
    always_comb begin
        next_ack   = bus_req;
        next_rdata = '0;
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADV_OFFSET:
                    next_rdata = {16'h0000, advert};
                LOAD_CTRL_OFFSET:
                    next_rdata = {31'h0, state == ST_LOAD};
                STRAP_STAT_OFFSET:
                    next_rdata = {28'h0000000, strap_word};
                default:
                    next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_strap_capture;
        capture_pulse && state == ST_STRAP;
    endsequence

    sequence s_loader_done;
        state == ST_LOAD && loader_valid && !reload_cmd;
    endsequence

    property p_defaults_applied;
        s_strap_capture |=> load_request
            && advert[BIT_SYM_PAUSE] == !strap_word[STRAP_MAN_FC]
            && !advert[BIT_REMOTE_FAULT] && !advert[BIT_ASYM_PAUSE]
            && advert[BIT_100_FULL] && advert[BIT_100_HALF]
            && advert[4:0] == SEL_IEEE_8023;
    endproperty

    a_reserved_zero: assert property (
        advert[15:14] == 2'b00 && !advert[9])
        else $error("reserved advertisement bits not zero");

    a_bus_ack_next: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle after request");

    a_adv_readback: assert property (
        bus_req && !wb_we_i && wb_adr_i == ADV_OFFSET
        |=> wb_dat_o == {16'h0000, $past(advert)})
        else $error("advertisement readback mismatch");

    a_strap_defaults: assert property (p_defaults_applied)
        else $error("strap defaults not applied");

    a_ten_defaults: assert property (
        s_strap_capture |=> advert[BIT_10_FULL] ==
            (strap_word[STRAP_AUTONEG] |
             (!strap_word[STRAP_SPEED] & strap_word[STRAP_DUPLEX]))
        && advert[BIT_10_HALF] ==
            (strap_word[STRAP_AUTONEG] | !strap_word[STRAP_SPEED]))
        else $error("10BASE-T defaults wrong");

    a_loader_image: assert property (
        s_loader_done |=> advert == clean_adv($past(loader_data))
            && !load_request)
        else $error("loader image not taken");

    a_pause_loaded: assert property (
        s_loader_done |=> advert[11:10] == $past(loader_data[11:10]))
        else $error("pause bits not from loader");

    a_reload_req: assert property (
        reload_cmd && state != ST_STRAP |=> load_request[*2])
        else $error("reload did not request loader");

    a_write_bits: assert property (
        wr_adv && state == ST_IDLE && wb_sel_i[1] && !reload_cmd
        |=> advert[BIT_REMOTE_FAULT] == $past(wb_dat_i[13])
            && advert[BIT_ASYM_PAUSE] == $past(wb_dat_i[11]))
        else $error("write to high byte lost");

    a_strap_held: assert property (
        state != ST_STRAP |=> $stable(strap_word))
        else $error("strap values changed after capture");

    // ==========================================================
    // Checks on reset, bus answer and storage
    sequence s_reset_release;
        $fell(rst);
    endsequence

    // Reset image is checked while reset is applied, so no disable here
    a_reset_image: assert property (
        disable iff (1'b0)
        rst |=> advert == ADV_RESET_BASE && !load_request
            && !wb_ack_o && wb_dat_o == 32'h0)
        else $error("reset image wrong");

    a_load_after_reset: assert property (
        s_reset_release |-> ##2 load_request && state == ST_LOAD)
        else $error("no loader request after reset");

    a_read_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");

    a_ack_needs_req: assert property (
        !bus_req |=> !wb_ack_o)
        else $error("ack without request");

    a_write_low_byte: assert property (
        wr_adv && state == ST_IDLE && wb_sel_i[0]
        |=> advert[7:0] == $past(wb_dat_i[7:0]))
        else $error("write to low byte lost");

    a_write_high_byte: assert property (
        wr_adv && state == ST_IDLE && wb_sel_i[1]
        |=> advert[BIT_100_FULL] == $past(wb_dat_i[8])
            && advert[13:10] == $past(wb_dat_i[13:10])
            && advert[15:14] == 2'b00 && !advert[9])
        else $error("write to high byte wrong");

    a_lane_hold: assert property (
        wr_adv && state == ST_IDLE && !wb_sel_i[1]
        |=> $stable(advert[15:8]))
        else $error("unselected byte lane changed");

    // Only a bus write may move the register once loading is over
    a_idle_hold: assert property (
        state == ST_IDLE && !wr_adv |=> $stable(advert))
        else $error("advertisement changed without a write");

    a_loader_ignored: assert property (
        !load_request && loader_valid && !wr_adv && state != ST_STRAP
        |=> $stable(advert))
        else $error("loader image taken without request");

    a_pending_read: assert property (
        bus_req && !wb_we_i && wb_adr_i == LOAD_CTRL_OFFSET
        |=> wb_dat_o[0] == ($past(state) == ST_LOAD)
            && wb_dat_o[31:1] == 31'h0)
        else $error("load pending readback wrong");

    a_strap_readback: assert property (
        bus_req && !wb_we_i && wb_adr_i == STRAP_STAT_OFFSET
        |=> wb_dat_o == {28'h0, $past(strap_word)})
        else $error("strap status readback wrong");

endmodule
`default_nettype wire

// *** eeprom_loader_model.sv ***
// Behavioural EEPROM loader that answers the block's image requests.
// Assumes the bench sets the reply delay and the image between requests.
`timescale 1ns/1ps
`default_nettype none
module eeprom_loader_model
    import autoneg_adv_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             load_request,
    input  wire logic [3:0]       delay,
    input  wire logic [ADV_W-1:0] image,
    output logic                  loader_valid,
    output logic [ADV_W-1:0]      loader_data
);
    logic [3:0] wait_cnt;

    // Idle data toggles so a stale image never looks like a fresh one
    always_ff @(posedge mclk) begin
        if (rst) begin
            loader_valid <= 1'b0;
            wait_cnt     <= 4'h0;
            loader_data  <= 16'h0;
        end else if (!loader_valid && load_request && wait_cnt >= delay) begin
            loader_valid <= 1'b1;
            loader_data  <= image;
        end else begin
            loader_valid <= 1'b0;
            wait_cnt     <= (load_request && !loader_valid) ? wait_cnt + 4'h1
                                                            : 4'h0;
            loader_data  <= ~loader_data;
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the advertisement register block.
// Assumes the package and the loader model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import autoneg_adv_pkg::*;
    logic             mclk = 1'b0;
    logic             rst = 1'b1;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [SEL_W-1:0] sel = '0;
    logic [DAT_W-1:0] wdat = '0;
    logic [DAT_W-1:0] rdat;
    logic             ack;
    logic [3:0]       straps = 4'h0;
    logic             valid;
    logic [ADV_W-1:0] ldata;
    logic             lreq;
    logic [ADV_W-1:0] advert;
    logic [3:0]       dly = 4'h1;
    logic [ADV_W-1:0] img = '0;
    logic [ADV_W-1:0] shadow;
    logic [DAT_W-1:0] got;
    int               errors = 0;
    int               checks = 0;
    int               cycles = 0;

    always #5 mclk = ~mclk;

    autoneg_advert_register u_dut (
        .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .autoneg_strap(straps[STRAP_AUTONEG]),
        .speed_strap(straps[STRAP_SPEED]),
        .duplex_strap(straps[STRAP_DUPLEX]),
        .manual_flow_ctrl_strap(straps[STRAP_MAN_FC]),
        .loader_valid(valid), .loader_data(ldata),
        .load_request(lreq), .advert(advert)
    );

    eeprom_loader_model u_loader (
        .mclk(mclk), .rst(rst), .load_request(lreq), .delay(dly),
        .image(img), .loader_valid(valid), .loader_data(ldata)
    );

    // ==========================================================
    // Checking and ending
    task automatic check(input logic [DAT_W-1:0] seen,
                         input logic [DAT_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            stop_test();
        end
    end

    function automatic logic [ADV_W-1:0] dflt(input logic [3:0] s);
        logic an, spd, dup, fc;
        {fc, dup, spd, an} = s;
        dflt = 16'h0181;
        dflt[10] = ~fc;
        dflt[6] = an | (~spd & dup);
        dflt[5] = an | ~spd;
    endfunction

    // ==========================================================
    // Bus and reset tasks, entered just after a rising edge
    task automatic bus(input logic w, input logic [ADR_W-1:0] a,
                       input logic [SEL_W-1:0] s, input logic [DAT_W-1:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wait_load();
        while (lreq !== 1'b0) @(posedge mclk);
    endtask

    task automatic do_reset(input logic [3:0] s);
        rst <= 1'b1;
        straps <= s;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        straps <= ~s;
        @(posedge mclk);
        #1;
        check(32'(advert), 32'(dflt(s)));
        check(32'(lreq), 32'h1);
        @(posedge mclk);
        wait_load();
        check({16'h0, advert}, {16'h0, img & 16'h3dff});
        bus(1'b0, STRAP_STAT_OFFSET, 4'hf, '0);
        check(got, {28'h0, s});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [DAT_W-1:0] d;
        logic [SEL_W-1:0] s;
        logic [15:0]      m;
        void'($urandom(32'h8e85));
        @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            img <= 16'($urandom);
            dly <= 4'($urandom % 5);
            do_reset(4'(i));
        end
        $display("test straps_and_loader done");
        shadow = img & 16'h3dff;
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hffffefff : ($urandom & ~32'h1000);
            s = (i == 0) ? 4'hf : 4'($urandom);
            m = {{8{s[1]}}, {8{s[0]}}} & 16'h3dff;
            shadow = (shadow & ~m) | (d[15:0] & m);
            bus(1'b1, ADV_OFFSET, s, d);
            check({16'h0, advert}, {16'h0, shadow});
            bus(1'b0, ADV_OFFSET, 4'hf, '0);
            check(got, {16'h0, shadow});
        end
        $display("test register_access done");
        bus(1'b1, 8'h10, 4'hf, 32'hffffffff);
        bus(1'b0, 8'h10, 4'hf, '0);
        check(got, 32'h0);
        bus(1'b0, ADV_OFFSET, 4'hf, '0);
        check(got, {16'h0, shadow});
        $display("test unmapped done");
        img <= 16'($urandom) | 16'h0c00;
        dly <= 4'd12;
        bus(1'b1, LOAD_CTRL_OFFSET, 4'h1, 32'h1);
        bus(1'b0, LOAD_CTRL_OFFSET, 4'hf, '0);
        check(got, 32'h1);
        wait_load();
        check({16'h0, advert}, {16'h0, img & 16'h3dff});
        bus(1'b0, LOAD_CTRL_OFFSET, 4'hf, '0);
        check(got, 32'h0);
        $display("test reload done");
        stop_test();
    end
endmodule
`default_nettype wire
